// ==== brake_abs_ctrl.sv ====
// Purpose: holding brake mode interlock and absolute encoder position handling
// Assumes: parameter port, drive state and encoder signals synchronous to ref_clk_i
// Notes:   a written position is held until the next controller switch-on
`timescale 1ns/1ps
module brake_abs_ctrl
  import brake_abs_pkg::*;
#(
  parameter int SETTLE_CNT = SETTLE_CYCLES
)(
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  // parameter access port
  input  wire logic [15:0] par_addr_i,
  input  wire logic        par_wr_i,
  input  wire logic        par_rd_i,
  input  wire logic [31:0] par_wdata_i,
  output logic      [31:0] par_rdata_o,
  output logic             par_ack_o,
  output logic             par_err_o,
  // drive state and power stage
  input  wire logic [3:0]  drive_state_i,
  input  wire logic        power_stage_active_i,
  input  wire logic        controller_on_i,
  input  wire logic        enable_req_i,
  output logic             enable_grant_o,
  output logic             enable_refused_o,
  // brake
  input  wire logic        brake_auto_release_i,
  output logic             brake_release_o,
  output logic             brake_error_o,
  // encoder
  input  wire logic        enc_valid_i,
  input  wire logic [31:0] enc_abs_pos_i,
  input  wire logic        enc_multiturn_i,
  input  wire logic        enc_step_i,
  input  wire logic        enc_cw_i,
  input  wire logic        direction_inversion_i,
  input  wire logic        standstill_i,
  output logic      [31:0] actual_pos_o,
  output logic             virtual_index_o,
  output logic             emulation_index_o,
  output logic             pos_set_busy_o,
  // warnings
  input  wire logic        warn_clear_i,
  output logic      [15:0] warning_latched_word_o,
  output logic      [15:0] warning_active_word_o
);
  typedef struct packed {
    phase_type   phase;
    logic        brake_mode;
    logic        brake_out;
    logic        brake_err;
    logic        grant;
    logic        refused;
    logic        warn_lat;
    logic [31:0] set_val;
    logic [31:0] pend_off;
    logic        pend;
    logic [31:0] off;
    logic [SETTLE_W-1:0] settle;
    logic        ack;
    logic        err;
    logic [31:0] rdata;
    logic        ctl_d;
    logic        idx;
  } ctrl_type;

  ctrl_type st_reg;
  ctrl_type st_next;

  logic [31:0] raw_pos;
  logic [31:0] actual;
  logic [31:0] abs_view;
  logic [31:0] set_limit;
  logic [31:0] landing;
  logic        state_ok;
  logic        step_up;
  logic        cnt_load;
  logic        wr_set;
  logic        wr_brake;
  logic        set_ok;

  // positive count is clockwise unless inverted
  assign step_up   = enc_cw_i ^ direction_inversion_i;
  assign cnt_load  = (st_reg.phase == PH_CAPTURE) && enc_valid_i;
  assign actual    = raw_pos + st_reg.off;
  // position the pending step lands on, so the index marks arrival at a boundary
  assign landing   = step_up ? actual + 32'h1 : actual - 32'h1;
  // singleturn reports one turn, multiturn the whole encoder range
  assign abs_view  = enc_multiturn_i ? {{(32-MULTI_BITS){1'b0}}, actual[MULTI_BITS-1:0]}
                                     : {{(32-TURN_BITS){1'b0}}, actual[TURN_BITS-1:0]};
  assign set_limit = enc_multiturn_i ? MULTI_LIMIT : SINGLE_LIMIT;
  assign state_ok  = (drive_state_i == DS_SWITCH_ON_DISABLED) ||
                     (drive_state_i == DS_READY_TO_SWITCH_ON);
  assign wr_set    = par_wr_i && (par_addr_i == ADDR_POS_SET);
  assign wr_brake  = par_wr_i && (par_addr_i == ADDR_BRAKE_SEL);
  // only at standstill, with a captured position and inside range
  assign set_ok    = standstill_i && (st_reg.phase == PH_RUN) &&
                     (par_wdata_i < set_limit);

  // mechanical counter, reloaded from the encoder at every startup
  pos_counter u_cnt (
    .ref_clk_i  (ref_clk_i),
    .nrst_i     (nrst_i),
    .load_i     (cnt_load),
    .load_val_i (enc_abs_pos_i),
    .step_i     (enc_step_i && !cnt_load),
    .up_i       (step_up),
    .pos_o      (raw_pos)
  );

  // next-state logic for brake, enable interlock, position set and parameter port
  always_comb begin
    st_next         = st_reg;
    st_next.grant   = 1'b0;
    st_next.refused = 1'b0;
    st_next.brake_err = 1'b0;
    st_next.ack     = 1'b0;
    st_next.err     = 1'b0;
    st_next.ctl_d   = controller_on_i;

    // startup capture of the absolute position
    if (cnt_load) begin
      st_next.phase = PH_RUN;
    end

    // latched warning: set wins over clear
    if (st_reg.phase == PH_CAPTURE) begin
      st_next.warn_lat = 1'b1;
    end else if (warn_clear_i) begin
      st_next.warn_lat = 1'b0;
    end

    // enable request is refused while the brake is held open by hand
    if (enable_req_i) begin
      if (st_reg.brake_mode == BRAKE_MANUAL) begin
        st_next.refused = 1'b1;
      end else begin
        st_next.grant = 1'b1;
      end
    end

    // written position becomes active on controller switch-on; it sits ahead of the
    // port so that a write on that same edge stays pending for the next switch-on
    if (controller_on_i && !st_reg.ctl_d && st_reg.pend) begin
      st_next.off  = st_reg.pend_off;
      st_next.pend = 1'b0;
    end

    // parameter port: one answer per access, the cycle after it
    if (par_wr_i || par_rd_i) begin
      st_next.ack = 1'b1;
    end
    if (par_rd_i) begin
      unique case (par_addr_i)
        ADDR_POS_SET:   st_next.rdata = st_reg.set_val;
        ADDR_BRAKE_SEL: st_next.rdata = {31'h0, st_reg.brake_mode};
        ADDR_ABS_READ:  st_next.rdata = abs_view;
        default: begin
          st_next.rdata = 32'h0;
          st_next.err   = 1'b1;
        end
      endcase
    end
    if (par_wr_i) begin
      unique case (par_addr_i)
        ADDR_POS_SET: begin
          if (set_ok) begin
            // remember value as offset against the present mechanical position
            st_next.set_val  = par_wdata_i;
            st_next.pend_off = par_wdata_i - raw_pos;
            st_next.pend     = 1'b1;
            st_next.settle   = SETTLE_W'(SETTLE_CNT);
          end else begin
            st_next.err = 1'b1;
          end
        end
        ADDR_BRAKE_SEL: begin
          if (par_wdata_i > {16'h0, BRAKE_MAX}) begin
            st_next.err = 1'b1;
          end else if (power_stage_active_i && par_wdata_i[0]) begin
            st_next.err       = 1'b1;
            st_next.brake_err = 1'b1;
          end else begin
            st_next.brake_mode = par_wdata_i[0];
          end
        end
        default: st_next.err = 1'b1; // read-only or unmapped
      endcase
    end

    // an active power stage always returns the brake to automatic
    if (power_stage_active_i) begin
      st_next.brake_mode = BRAKE_AUTO;
    end

    // brake output: manual release only in the two idle states, held outside them; automatic follows brake_auto_release_i
    if (st_next.brake_mode == BRAKE_MANUAL) begin
      st_next.brake_out = state_ok;
    end else begin
      st_next.brake_out = brake_auto_release_i;
    end

    // settle guard counts down after each accepted write
    if (st_reg.settle != '0 && !(wr_set && set_ok)) begin
      st_next.settle = st_reg.settle - SETTLE_W'(1);
    end

    // index marks each step that lands on a turn boundary of the shifted position
    st_next.idx = (st_reg.phase == PH_RUN) &&
                  (landing[TURN_BITS-1:0] == '0) && !st_reg.idx &&
                  enc_step_i;
  end

  // single state register; a power cycle clears the offset and reloads
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg.phase      <= PH_CAPTURE;
      st_reg.brake_mode <= BRAKE_AUTO;
      st_reg.brake_out  <= 1'b0;
      st_reg.brake_err  <= 1'b0;
      st_reg.grant      <= 1'b0;
      st_reg.refused    <= 1'b0;
      st_reg.warn_lat   <= 1'b1;
      st_reg.set_val    <= POS_RESET;
      st_reg.pend_off   <= POS_RESET;
      st_reg.pend       <= 1'b0;
      st_reg.off        <= POS_RESET;
      st_reg.settle     <= '0;
      st_reg.ack        <= 1'b0;
      st_reg.err        <= 1'b0;
      st_reg.rdata      <= POS_RESET;
      st_reg.ctl_d      <= 1'b0;
      st_reg.idx        <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs
  assign par_rdata_o       = st_reg.rdata;
  assign par_ack_o         = st_reg.ack;
  assign par_err_o         = st_reg.err;
  assign enable_grant_o    = st_reg.grant;
  assign enable_refused_o  = st_reg.refused;
  assign brake_release_o   = st_reg.brake_out;
  assign brake_error_o     = st_reg.brake_err;
  assign actual_pos_o      = actual;
  assign virtual_index_o   = st_reg.idx;
  assign emulation_index_o = st_reg.idx;
  assign pos_set_busy_o    = (st_reg.settle != '0);
  // active word follows the capture phase; latched holds until cleared
  assign warning_active_word_o  = 16'(st_reg.phase == PH_CAPTURE) << WARN_POS_INVALID;
  assign warning_latched_word_o = 16'(st_reg.warn_lat) << WARN_POS_INVALID;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  a_brake_forced_auto: assert property (
    power_stage_active_i |=> st_reg.brake_mode == BRAKE_AUTO)
    else $error("brake mode not automatic with power stage active");

  a_brake_state_gate: assert property (
    (st_next.brake_mode == BRAKE_MANUAL && !state_ok) |=> !brake_release_o)
    else $error("manual brake output outside permitted states");

  a_enable_refuse: assert property (
    (enable_req_i && st_reg.brake_mode == BRAKE_MANUAL) |=> enable_refused_o && !enable_grant_o)
    else $error("enable granted with manual brake");

  a_manual_err_on: assert property (
    (wr_brake && power_stage_active_i && par_wdata_i == 32'h1) |=> brake_error_o && par_err_o)
    else $error("no error on manual release with power stage on");

  a_warn_until_cap: assert property (
    (st_reg.phase == PH_CAPTURE) |-> warning_active_word_o[WARN_POS_INVALID] &&
                                     warning_latched_word_o[WARN_POS_INVALID])
    else $error("invalid position warning missing");

  a_set_range_bad: assert property (
    (wr_set && par_wdata_i >= set_limit) |=> par_ack_o && par_err_o && $stable(st_reg.set_val))
    else $error("out of range position accepted");

  a_set_deferred: assert property (
    (wr_set && set_ok && !(controller_on_i && !st_reg.ctl_d)) |=> $stable(st_reg.off) && st_reg.pend)
    else $error("position applied before switch-on");

  a_settle_busy: assert property (
    (wr_set && set_ok) |=> pos_set_busy_o [*8])
    else $error("settle guard not running after write");

  a_dir_count: assert property (
    (st_reg.phase == PH_RUN && enc_step_i && step_up) |=> raw_pos == $past(raw_pos) + 32'h1)
    else $error("positive step did not count up");

  a_single_span: assert property (
    (par_rd_i && par_addr_i == ADDR_ABS_READ && !enc_multiturn_i) |=> par_rdata_o < SINGLE_LIMIT)
    else $error("singleturn read beyond one turn");

  // enable with automatic brake, and brake output with the power stage on
  a_grant_auto: assert property (
    (enable_req_i && st_reg.brake_mode == BRAKE_AUTO) |=> enable_grant_o && !enable_refused_o)
    else $error("enable refused with automatic brake");

  a_brake_auto_out: assert property (
    power_stage_active_i |=> brake_release_o == $past(brake_auto_release_i))
    else $error("brake output not automatic with power stage active");

  // capture, position set and switch-on
  a_abs_capture: assert property (
    cnt_load |=> raw_pos == $past(enc_abs_pos_i) && st_reg.phase == PH_RUN)
    else $error("encoder position not captured");

  a_set_moving: assert property (
    (wr_set && !standstill_i) |=> par_err_o && $stable(st_reg.set_val))
    else $error("position set accepted while moving");

  a_set_good_ok: assert property (
    (wr_set && standstill_i && st_reg.phase == PH_RUN && par_wdata_i < set_limit) |=>
    par_ack_o && !par_err_o && st_reg.pend)
    else $error("valid position set refused");

  a_set_applied: assert property (
    (controller_on_i && !st_reg.ctl_d && st_reg.pend) |=> st_reg.off == $past(st_reg.pend_off))
    else $error("pending position not applied at switch-on");

  // counting, span and index
  a_dir_count_dn: assert property (
    (st_reg.phase == PH_RUN && enc_step_i && !step_up) |=> raw_pos == $past(raw_pos) - 32'h1)
    else $error("negative step did not count down");

  a_multi_span: assert property (
    (par_rd_i && par_addr_i == ADDR_ABS_READ && enc_multiturn_i) |=> par_rdata_o < MULTI_LIMIT)
    else $error("multiturn read beyond encoder range");

  a_index_landing: assert property (
    (st_reg.phase == PH_RUN && enc_step_i && !st_reg.idx && landing[TURN_BITS-1:0] == '0) |=>
    virtual_index_o && emulation_index_o)
    else $error("no index pulse on turn boundary");

  a_index_no_step: assert property (
    !enc_step_i |=> !virtual_index_o && !emulation_index_o)
    else $error("index pulse without a step");

  c_manual_release: cover property (st_reg.brake_mode == BRAKE_MANUAL && brake_release_o);
  c_pos_applied:    cover property (st_reg.pend ##1 !st_reg.pend);
  c_capture_done:   cover property (st_reg.phase == PH_CAPTURE ##1 st_reg.phase == PH_RUN);
  c_enable_refused: cover property (enable_refused_o);
  c_index_pulse:    cover property (virtual_index_o);
endmodule : brake_abs_ctrl

// ==== brake_abs_pkg.sv ====
// Purpose: shared constants for the brake and absolute position controller
// Assumes: one 10 MHz clock, parameter port at the printed parameter addresses
// Notes:   summary of operation follows
// Summary of operation
// - brake mode 0 means automatic brake handling, 1 means manual release; reset 0
// - manual brake release drives the output only in switch-on-disabled or ready states
// - power stage becoming active forces brake mode back to automatic
// - power stage enable request refused while brake is manually released
// - with power stage enabled, a manual release request raises an error
// - at startup read encoder position, present it read-only in user units
// - new absolute position accepted at standstill, power stage on or off
// - set range 0..turn-1 singleturn, 0..4096*turn-1 multiturn, turn 16384
// - written position active at next switch-on; host waits one second first
// - changing absolute position moves virtual and emulation index pulses
// - singleturn value 0 places index pulse at current mechanical position
// - position invalid until captured; bit 13 set in latched and active warnings
// - readable position spans one turn singleturn, whole range multiturn
// - internal position counts negative on underrun; power cycle reloads encoder value
// - positive direction is clockwise facing shaft unless inversion applied
package brake_abs_pkg;
  // parameter addresses
  localparam logic [15:0] ADDR_POS_SET   = 16'h052c;
  localparam logic [15:0] ADDR_BRAKE_SEL = 16'h0814;
  localparam logic [15:0] ADDR_ABS_READ  = 16'h1e1e;
  // brake mode codes and highest accepted value
  localparam logic        BRAKE_AUTO     = 1'h0;
  localparam logic        BRAKE_MANUAL   = 1'h1;
  localparam logic [15:0] BRAKE_MAX      = 16'h0001;
  // drive state codes as seen on drive_state_i
  localparam logic [3:0]  DS_SWITCH_ON_DISABLED = 4'h2;
  localparam logic [3:0]  DS_READY_TO_SWITCH_ON = 4'h3;
  // position scaling: one turn is 2**TURN_BITS user units, 4096 turns multiturn
  localparam int          TURN_BITS      = 14;
  localparam int          MULTI_BITS     = 26;
  localparam logic [31:0] ONE_TURN_MAX   = 32'h0000_4000;
  localparam logic [31:0] MULTI_TURNS    = 32'h0000_1000;
  localparam logic [31:0] SINGLE_LIMIT   = ONE_TURN_MAX;
  localparam logic [31:0] MULTI_LIMIT    = ONE_TURN_MAX * MULTI_TURNS;
  localparam logic [31:0] POS_RESET      = 32'h0000_0000;
  // warning word layout
  localparam int          WARN_POS_INVALID = 13;
  // commit guard after a position write
  localparam int          CLK_HZ         = 10_000_000;
  localparam int          SETTLE_TIME_MS = 1000;
  localparam int          SETTLE_CYCLES  = SETTLE_TIME_MS * (CLK_HZ / 1000);
  localparam int          SETTLE_W       = 24;
  // startup phases
  typedef enum logic {PH_CAPTURE, PH_RUN} phase_type;
endpackage : brake_abs_pkg

// ==== enc_model.sv ====
// Purpose: behavioural motor encoder on the far side of the position logic
// Assumes: steps issued on falling edges, one user unit each
// Notes:   the data word is junk until valid rises
`timescale 1ns/1ps
module enc_model #(
  parameter logic [31:0] ABS_POS   = 32'h0000_1234,
  parameter int          VALID_DLY = 5
)(
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  output logic             valid_o,
  output logic      [31:0] abs_pos_o,
  output logic             step_o,
  output logic             cw_o
);
  int unsigned age;
  // serial readout takes a few cycles after reset before the value is usable
  always @(negedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) age <= 0;
    else if (age < VALID_DLY) age <= age + 1;
  end
  assign valid_o = (age >= VALID_DLY);
  // changing junk before valid, so a capture taken too early shows up
  assign abs_pos_o = valid_o ? ABS_POS : ~(ABS_POS + age);
  // one step a cycle, then the step line drops
  task automatic move(input int n, input logic cw);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk_i);
      step_o = 1'b1;
      cw_o = cw;
    end
    @(negedge ref_clk_i);
    step_o = 1'b0;
  endtask : move
  initial begin
    step_o = 1'b0;
    cw_o = 1'b0;
  end
endmodule : enc_model

// ==== pos_counter.sv ====
// Purpose: mechanical position counter fed by encoder steps
// Assumes: step and direction synchronous to the clock
// Notes:   counts freely through zero into negative values
`timescale 1ns/1ps
module pos_counter
  import brake_abs_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        load_i,
  input  wire logic [31:0] load_val_i,
  input  wire logic        step_i,
  input  wire logic        up_i,
  output logic      [31:0] pos_o
);
  typedef struct packed {
    logic [31:0] pos;
  } cnt_type;

  cnt_type st_reg;
  cnt_type st_next;

  // load has priority so a fresh encoder reading is never off by a step
  always_comb begin
    st_next = st_reg;
    if (load_i) begin
      st_next.pos = load_val_i;
    end else if (step_i) begin
      st_next.pos = up_i ? st_reg.pos + 32'h1 : st_reg.pos - 32'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_reg.pos <= POS_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pos_o = st_reg.pos;
endmodule : pos_counter

// ==== testbench.sv ====
// Purpose: self-checking bench for the brake and absolute position controller
// Assumes: inputs change on falling edges, outputs sampled there
// Notes:   settle count cut to 20 cycles to keep the run short
`timescale 1ns/1ps
module testbench
  import brake_abs_pkg::*;
;
  localparam logic [31:0] ENC_ABS = 32'h0000_1234;
  localparam int          SETTLE  = 20;
  logic        ref_clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, en_req = 1'b0;
  logic        pwr = 1'b0, ctl_on = 1'b0, brk_auto = 1'b0, multi = 1'b0, inv = 1'b0;
  logic        still = 1'b1, wclr = 1'b0, ack, perr, grant, refused, brk_rel, brk_err;
  logic        vidx, eidx, busy, ev, estep, ecw, e, berr_seen = 1'b0;
  logic [3:0]  state = DS_SWITCH_ON_DISABLED;
  logic [15:0] addr = 16'h0000, warn_l, warn_a;
  logic [31:0] wdata = 32'h0000_0000, rdata, actual, epos, got;
  int          err_total = 0, total_checks = 0, vcnt = 0, ecnt = 0, cyc = 0;

  always #50 ref_clk = ~ref_clk;

  brake_abs_ctrl #(.SETTLE_CNT(SETTLE)) DUT (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .par_addr_i(addr), .par_wr_i(wr),
    .par_rd_i(rd), .par_wdata_i(wdata), .par_rdata_o(rdata), .par_ack_o(ack),
    .par_err_o(perr), .drive_state_i(state), .power_stage_active_i(pwr),
    .controller_on_i(ctl_on), .enable_req_i(en_req), .enable_grant_o(grant),
    .enable_refused_o(refused), .brake_auto_release_i(brk_auto),
    .brake_release_o(brk_rel), .brake_error_o(brk_err), .enc_valid_i(ev),
    .enc_abs_pos_i(epos), .enc_multiturn_i(multi), .enc_step_i(estep), .enc_cw_i(ecw),
    .direction_inversion_i(inv), .standstill_i(still), .actual_pos_o(actual),
    .virtual_index_o(vidx), .emulation_index_o(eidx), .pos_set_busy_o(busy),
    .warn_clear_i(wclr), .warning_latched_word_o(warn_l), .warning_active_word_o(warn_a));

  enc_model #(.ABS_POS(ENC_ABS)) enc (
    .ref_clk_i(ref_clk), .nrst_i(nrst), .valid_o(ev), .abs_pos_o(epos),
    .step_o(estep), .cw_o(ecw));

  // pulse counters and hang guard; the ceiling is far above the planned run
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (vidx) vcnt <= vcnt + 1;
    if (eidx) ecnt <= ecnt + 1;
    if (brk_err) berr_seen <= 1'b1;
    if (cyc == 6000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end

  task automatic end_sim();
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick

  // one-cycle strobe, answer expected one cycle later
  task automatic par(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    addr = a;
    wdata = d;
    wr = w;
    rd = !w;
    @(negedge ref_clk);
    wr = 1'b0;
    rd = 1'b0;
    chk(ack, 1'b1);
    got = rdata;
    e = perr;
  endtask : par

  task automatic enable_try();
    @(negedge ref_clk);
    en_req = 1'b1;
    @(negedge ref_clk);
    en_req = 1'b0;
  endtask : enable_try

  // write a position, let the guard run out, then switch the controller on
  task automatic apply_pos(input logic [31:0] v);
    par(1'b1, ADDR_POS_SET, v);
    chk(busy, 1'b1);
    tick(SETTLE + 2);
    chk(busy, 1'b0);
    ctl_on = 1'b0;
    tick(2);
    ctl_on = 1'b1;
    tick(3);
  endtask : apply_pos

  task automatic do_reset();
    nrst = 1'b0;
    // the host never restarts the power stage on its own after a reset
    pwr = 1'b0;
    tick(8);
    chk(warn_l, 16'h2000);
    chk(warn_a, 16'h2000);
    chk(brk_rel, 1'b0);
    nrst = 1'b1;
    tick(12);
    chk(warn_a[13], 1'b0);
    chk(warn_l[13], 1'b1);
    chk(actual, ENC_ABS);
    par(1'b0, ADDR_ABS_READ, 32'h0);
    chk(got, ENC_ABS);
  endtask : do_reset

  task automatic t_warn();
    @(negedge ref_clk);
    wclr = 1'b1;
    @(negedge ref_clk);
    wclr = 1'b0;
    tick(1);
    chk(warn_l, 16'h0000);
    par(1'b1, ADDR_ABS_READ, 32'h5);
    chk(e, 1'b1);
    par(1'b1, 16'h0800, 32'h0);
    chk(e, 1'b1);
  endtask : t_warn

  task automatic t_brake();
    par(1'b1, ADDR_BRAKE_SEL, 32'h1);
    chk(e, 1'b0);
    tick(1);
    chk(brk_rel, 1'b1);
    par(1'b0, ADDR_BRAKE_SEL, 32'h0);
    chk(got, 32'h1);
    enable_try();
    chk({grant, refused}, 2'b01);
    state = 4'h6;
    tick(2);
    chk(brk_rel, 1'b0);
    state = DS_READY_TO_SWITCH_ON;
    tick(2);
    chk(brk_rel, 1'b1);
    par(1'b1, ADDR_BRAKE_SEL, 32'h2);
    chk(e, 1'b1);
  endtask : t_brake

  task automatic t_power();
    state = 4'h7;
    pwr = 1'b1;
    tick(2);
    par(1'b0, ADDR_BRAKE_SEL, 32'h0);
    chk(got, 32'h0);
    berr_seen = 1'b0;
    par(1'b1, ADDR_BRAKE_SEL, 32'h1);
    tick(1);
    chk({e, berr_seen}, 2'b11);
    enable_try();
    chk({grant, refused}, 2'b10);
    brk_auto = 1'b1;
    tick(2);
    chk(brk_rel, 1'b1);
    brk_auto = 1'b0;
    tick(2);
    chk(brk_rel, 1'b0);
    // a safe-off request drops both channels in one step, so power goes at once
    pwr = 1'b0;
    state = DS_READY_TO_SWITCH_ON;
  endtask : t_power

  task automatic t_pos_range();
    still = 1'b0;
    par(1'b1, ADDR_POS_SET, 32'h10);
    chk(e, 1'b1);
    still = 1'b1;
    par(1'b1, ADDR_POS_SET, SINGLE_LIMIT);
    chk(e, 1'b1);
    pwr = 1'b1;
    par(1'b1, ADDR_POS_SET, SINGLE_LIMIT - 1);
    chk(e, 1'b0);
    pwr = 1'b0;
    multi = 1'b1;
    par(1'b1, ADDR_POS_SET, MULTI_LIMIT);
    chk(e, 1'b1);
    par(1'b1, ADDR_POS_SET, 32'hffff_ffff);
    chk(e, 1'b1);
    par(1'b1, ADDR_POS_SET, MULTI_LIMIT - 1);
    chk(e, 1'b0);
    par(1'b0, ADDR_POS_SET, 32'h0);
    chk(got, MULTI_LIMIT - 1);
    chk(actual, ENC_ABS);
  endtask : t_pos_range

  task automatic t_pos_move();
    apply_pos(32'h0);
    chk(actual, 32'h0);
    enc.move(3, 1'b0);
    tick(1);
    chk(actual, 32'hffff_fffd);
    par(1'b0, ADDR_ABS_READ, 32'h0);
    chk(got, 32'h03ff_fffd);
    multi = 1'b0;
    apply_pos(32'h0);
    chk(actual, 32'h0);
    enc.move(2, 1'b0);
    vcnt = 0;
    ecnt = 0;
    enc.move(2, 1'b1);
    tick(2);
    chk({vcnt[7:0], ecnt[7:0]}, 16'h0101);
    // inversion goes in before the position write, and the limit sits above zero
    inv = 1'b1;
    apply_pos(32'h0000_0010);
    chk(actual, 32'h0000_0010);
    enc.move(2, 1'b1);
    tick(1);
    chk(actual, 32'h0000_000e);
    inv = 1'b0;
  endtask : t_pos_move

  initial begin
    do_reset();
    t_warn();
    t_brake();
    t_power();
    t_pos_range();
    t_pos_move();
    ctl_on = 1'b0;
    do_reset();
    end_sim();
  end
endmodule : testbench
